// >>> common/lpc_defines.svh
// Constants and register map of the panel control timing block
`ifndef LPC_DEFINES_SVH
`define LPC_DEFINES_SVH
`define LPC_CTRL_ADDR   12'h000
`define LPC_STAT_ADDR   12'h004
`define LPC_CTRL_MSB    8
`define LPC_CTRL_RST    9'h000
`define LPC_STAT_HCNT   16
`define LPC_HCNT_MAX    12'hfff
`define LPC_HS_LEAD     12'd2
`define LPC_LL_AT_N     12'd1031
`define LPC_LL_AT_W     12'd1285
`define LPC_LL_W_N      12'd8
`define LPC_LL_W_W      12'd10
`define LPC_LL_SHORT_NS 120
`define LPC_LL_LONG_N_NS 250
`define LPC_LL_LONG_W_NS 500
`define LPC_GE_AT_N     12'd904
`define LPC_GE_AT_W     12'd1147
`define LPC_GE_W_N      12'd159
`define LPC_GE_W_W      12'd180
`define LPC_GE_T1_N_NS  2400
`define LPC_GE_T2_N_NS  2900
`define LPC_GE_T3_N_NS  3400
`define LPC_GE_T1_W_NS  2100
`define LPC_GE_T2_W_NS  2600
`define LPC_GE_T3_W_NS  3100
`define LPC_SC_AT_N     12'd1031
`define LPC_SC_AT_W     12'd1283
`define LPC_SC_W_N      12'd684
`define LPC_SC_W_W      12'd724
`define LPC_RS_AT_N     12'd368
`define LPC_RS_AT_W     12'd565
`define LPC_REV1_AT_N   12'd390
`define LPC_REV2_AT_N   12'd371
`define LPC_REV_AT_W    12'd567
`define LPC_BLANK_TICKS 12'd2000
`define LPC_FAIL_ZONE   12'd1050
`define LPC_RO_1H_MASK  8'h49
`define LPC_RO_LL_LONG  8'he4
`define LPC_RO_GE2      3'd3
`define LPC_RO_GE3      3'd6
`define LPC_SKEW_BASE   3'd1
`define LPC_CLK_HIGH    3'd3
`define LPC_PH_MAX      3'd7
`endif

// >>> common/lpc_pkg.sv
// Types shared by the panel control timing block
package lpc_pkg;
    typedef struct packed {
        logic       failOn;
        logic [2:0] skew;
        logic       ditherSelect;
        logic [2:0] reversalOption;
        logic       wide;
    } lpc_cfg_t;
    typedef struct packed {
        logic horizStartPulse;
        logic lineLatchPulse;
        logic gateEnable;
        logic rowShiftClock;
        logic rowStartPulse;
        logic polarityReversal;
    } lpc_ctrl_out_t;
    typedef enum logic {
        LN_ACTIVE = 1'b0,
        LN_BLANK  = 1'b1
    } lpc_line_t;
endpackage : lpc_pkg

// >>> hw/lpc_timing.sv
// Panel control pulse generator with APB configuration
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`include "lpc_defines.svh"
module lpc_timing (
    input  wire logic                  core_clk,          // Core clock
    input  wire logic                  rst,               // Sync reset
    input  wire logic                  systemResetN,      // Reset pin
    input  wire logic                  pixelClock,        // Link pixel clock
    input  wire logic                  dataEnable,        // Data enable
    input  wire logic [23:0]           rgbIn,             // R,G,B bytes
    input  wire logic                  psel,              // APB select
    input  wire logic                  penable,           // APB enable
    input  wire logic                  pwrite,            // APB write
    input  wire logic [11:0]           paddr,             // APB address
    input  wire logic [31:0]           pwdata,            // APB write data
    output logic [31:0]                prdata,            // APB read data
    output logic                       pready,            // APB ready
    output logic                       pslverr,           // APB error
    output lpc_pkg::lpc_ctrl_out_t     ctrlOut,           // Driver pulses
    output logic [17:0]                colourOut,         // 6-bit R,G,B
    output logic                       columnOutputClock  // Column clock
);
    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [2:0]  pcSync_q;
    logic [1:0]  deSync_q;
    logic [1:0]  rstnSync_q;
    logic [23:0] rgbS1_q;
    logic [23:0] rgbS2_q;
    logic        sysRst;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pcSync_q   <= '0;
            deSync_q   <= '0;
            rstnSync_q <= '0;
            rgbS1_q    <= '0;
            rgbS2_q    <= '0;
        end else begin
            pcSync_q   <= {pcSync_q[1:0], pixelClock};
            deSync_q   <= {deSync_q[0], dataEnable};
            rstnSync_q <= {rstnSync_q[0], systemResetN};
            rgbS1_q    <= rgbIn;
            rgbS2_q    <= rgbS1_q;
        end
    end

    assign sysRst = rst | ~rstnSync_q[1];

    // ****************************************
    // Pixel tick and capture
    // ****************************************
    logic        pixTick_q;
    logic        deCap_q;
    logic [23:0] rgbCap_q;

    // Data and clock share sync depth, so edge sampling stays aligned
    always_ff @(posedge core_clk) begin
        if (sysRst) begin
            pixTick_q <= 1'b0;
            deCap_q   <= 1'b0;
            rgbCap_q  <= '0;
        end else begin
            pixTick_q <= pcSync_q[1] & ~pcSync_q[2];
            if (pcSync_q[1] & ~pcSync_q[2]) begin
                deCap_q  <= deSync_q[1];
                rgbCap_q <= rgbS2_q;
            end
        end
    end

    // ****************************************
    // Configuration decode
    // ****************************************
    localparam logic [7:0]  OneHMask = `LPC_RO_1H_MASK;
    localparam logic [7:0]  LlLongMask = `LPC_RO_LL_LONG;
    localparam logic [11:0] LlLongN = 12'((`LPC_LL_W_N * `LPC_LL_LONG_N_NS
        + `LPC_LL_SHORT_NS - 1) / `LPC_LL_SHORT_NS);
    localparam logic [11:0] LlLongW = 12'((`LPC_LL_W_W * `LPC_LL_LONG_W_NS
        + `LPC_LL_SHORT_NS - 1) / `LPC_LL_SHORT_NS);
    localparam logic [11:0] Ge2N = 12'((`LPC_GE_W_N * `LPC_GE_T2_N_NS
        + `LPC_GE_T1_N_NS - 1) / `LPC_GE_T1_N_NS);
    localparam logic [11:0] Ge3N = 12'((`LPC_GE_W_N * `LPC_GE_T3_N_NS
        + `LPC_GE_T1_N_NS - 1) / `LPC_GE_T1_N_NS);
    localparam logic [11:0] Ge2W = 12'((`LPC_GE_W_W * `LPC_GE_T2_W_NS
        + `LPC_GE_T1_W_NS - 1) / `LPC_GE_T1_W_NS);
    localparam logic [11:0] Ge3W = 12'((`LPC_GE_W_W * `LPC_GE_T3_W_NS
        + `LPC_GE_T1_W_NS - 1) / `LPC_GE_T1_W_NS);

    logic [`LPC_CTRL_MSB:0] ctrl_q;
    lpc_pkg::lpc_cfg_t      cfg;
    logic                   single;
    logic                   llLong;
    logic [11:0]            pAt [3];
    logic [11:0]            pW [3];
    logic [11:0]            rowAt;
    logic [11:0]            revAt;

    assign cfg    = ctrl_q;
    assign single = OneHMask[cfg.reversalOption];
    assign llLong = LlLongMask[cfg.reversalOption];

    always_comb begin
        pAt[0] = cfg.wide ? `LPC_LL_AT_W : `LPC_LL_AT_N;
        pAt[1] = cfg.wide ? `LPC_GE_AT_W : `LPC_GE_AT_N;
        pAt[2] = cfg.wide ? `LPC_SC_AT_W : `LPC_SC_AT_N;
        rowAt  = cfg.wide ? `LPC_RS_AT_W : `LPC_RS_AT_N;
        if (cfg.wide) begin
            revAt = `LPC_REV_AT_W;
        end else begin
            revAt = single ? `LPC_REV1_AT_N : `LPC_REV2_AT_N;
        end
        if (llLong) begin
            pW[0] = cfg.wide ? LlLongW : LlLongN;
        end else begin
            pW[0] = cfg.wide ? `LPC_LL_W_W : `LPC_LL_W_N;
        end
        if (cfg.reversalOption >= `LPC_RO_GE3) begin
            pW[1] = cfg.wide ? Ge3W : Ge3N;
        end else if (cfg.reversalOption >= `LPC_RO_GE2) begin
            pW[1] = cfg.wide ? Ge2W : Ge2N;
        end else begin
            pW[1] = cfg.wide ? `LPC_GE_W_W : `LPC_GE_W_N;
        end
        pW[2] = cfg.wide ? `LPC_SC_W_W : `LPC_SC_W_N;
    end

    // ****************************************
    // Line tracking
    // ****************************************
    logic               dePrev_q;
    logic [11:0]        hCnt_q;
    logic [11:0]        lowCnt_q;
    lpc_pkg::lpc_line_t lineSt_q;
    logic               deRise;
    logic               failZone;
    logic               start;
    logic [11:0]        hNext;

    assign deRise   = deCap_q & ~dePrev_q;
    // Stray enable edges in the first 1050 ticks of a line are dropped only when enabled
    assign failZone = cfg.failOn && lineSt_q == lpc_pkg::LN_ACTIVE
                      && hCnt_q < `LPC_FAIL_ZONE;
    assign start    = pixTick_q & deRise & ~failZone;
    assign hNext    = start ? '0 :
                      (hCnt_q == `LPC_HCNT_MAX) ? hCnt_q : hCnt_q + 12'd1;

    always_ff @(posedge core_clk) begin
        if (sysRst) begin
            dePrev_q <= 1'b0;
            hCnt_q   <= `LPC_HCNT_MAX;
            lowCnt_q <= '0;
            lineSt_q <= lpc_pkg::LN_BLANK;
        end else if (pixTick_q) begin
            dePrev_q <= deCap_q;
            hCnt_q   <= hNext;
            if (deCap_q) begin
                lowCnt_q <= '0;
            end else if (lowCnt_q != `LPC_HCNT_MAX) begin
                lowCnt_q <= lowCnt_q + 12'd1;
            end
            if (start) begin
                lineSt_q <= lpc_pkg::LN_ACTIVE;
            end else if (lowCnt_q >= `LPC_BLANK_TICKS) begin
                lineSt_q <= lpc_pkg::LN_BLANK;
            end
        end
    end

    // ****************************************
    // Start, row start and polarity
    // ****************************************
    logic horizStart_q;
    logic rowArm_q;
    logic rowStart_q;
    logic lineOdd_q;
    logic frameOdd_q;
    logic polarity_q;

    always_ff @(posedge core_clk) begin
        if (sysRst) begin
            horizStart_q <= 1'b0;
        end else if (pixTick_q) begin
            horizStart_q <= start;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sysRst) begin
            rowArm_q   <= 1'b0;
            rowStart_q <= 1'b0;
            frameOdd_q <= 1'b0;
        end else if (pixTick_q) begin
            if (start && lineSt_q == lpc_pkg::LN_BLANK) begin
                rowArm_q   <= 1'b1;
                frameOdd_q <= ~frameOdd_q;
            end else if (hNext == rowAt) begin
                rowArm_q <= 1'b0;
            end
            // Same point of the next line ends it: one line high
            if (hNext == rowAt) begin
                rowStart_q <= rowArm_q;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sysRst) begin
            lineOdd_q  <= 1'b0;
            polarity_q <= 1'b0;
        end else if (pixTick_q) begin
            if (start) begin
                lineOdd_q <= ~lineOdd_q;
            end
            if (hNext == revAt && (single || lineOdd_q)) begin
                polarity_q <= ~polarity_q;
            end
        end
    end

    // ****************************************
    // Latch, gate enable and shift pulses
    // ****************************************
    logic [2:0]  pulse_q;
    logic [11:0] wCnt_q [3];
    logic [11:0] hiCnt_q [3];

    for (genvar i = 0; i < 3; i++) begin : g_pulse
        // Counted down, so a pulse may run past the next line start
        always_ff @(posedge core_clk) begin
            if (sysRst) begin
                pulse_q[i] <= 1'b0;
                wCnt_q[i]  <= '0;
            end else if (pixTick_q) begin
                if (hNext == pAt[i]) begin
                    pulse_q[i] <= 1'b1;
                    wCnt_q[i]  <= pW[i] - 12'd1;
                end else if (pulse_q[i]) begin
                    if (wCnt_q[i] == '0) begin
                        pulse_q[i] <= 1'b0;
                    end else begin
                        wCnt_q[i] <= wCnt_q[i] - 12'd1;
                    end
                end
            end
        end
        always_ff @(posedge core_clk) begin
            if (sysRst) begin
                hiCnt_q[i] <= '0;
            end else if (pixTick_q) begin
                hiCnt_q[i] <= pulse_q[i] ? hiCnt_q[i] + 12'd1 : '0;
            end
        end
    end

    assign ctrlOut = '{horizStartPulse:  horizStart_q,
                       lineLatchPulse:   pulse_q[0],
                       gateEnable:       pulse_q[1],
                       rowShiftClock:    pulse_q[2],
                       rowStartPulse:    rowStart_q,
                       polarityReversal: polarity_q};

    // ****************************************
    // Colour path
    // ****************************************
    logic [17:0] reduced;
    logic [17:0] s1_q;
    logic [17:0] s2_q;
    logic [17:0] colour_q;
    logic [2:0]  valid_q;
    logic        pixOdd_q;
    logic [1:0]  thr;

    assign thr = {lineOdd_q ^ frameOdd_q, pixOdd_q};

    for (genvar ch = 0; ch < 3; ch++) begin : g_dither
        logic [7:0] c;
        logic       inc;
        assign c   = rgbCap_q[ch*8 +: 8];
        assign inc = (c[1:0] > thr) && (c[7:2] != 6'h3f);
        // Select high: six-bit input on the upper lanes, no dithering
        assign reduced[ch*6 +: 6] = cfg.ditherSelect ? c[7:2] :
                                    6'(c[7:2] + {5'h00, inc});
    end

    // Three stages put the first word two ticks after the start pulse
    always_ff @(posedge core_clk) begin
        if (sysRst) begin
            s1_q     <= '0;
            s2_q     <= '0;
            colour_q <= '0;
            valid_q  <= '0;
            pixOdd_q <= 1'b0;
        end else if (pixTick_q) begin
            s1_q     <= reduced;
            s2_q     <= s1_q;
            colour_q <= s2_q;
            valid_q  <= {valid_q[1:0], deCap_q};
            pixOdd_q <= ~pixOdd_q;
        end
    end

    assign colourOut = colour_q;

    // ****************************************
    // Column output clock
    // ****************************************
    logic [2:0] ph_q;
    logic [2:0] phNext;
    logic [2:0] riseAt;
    logic       colClk_q;

    assign phNext = pixTick_q ? '0 :
                    (ph_q == `LPC_PH_MAX) ? ph_q : ph_q + 3'd1;
    // Limitation: needs eight core cycles per pixel for all skew codes
    assign riseAt = cfg.skew[2] ? {1'b0, cfg.skew[1:0]} :
                    {1'b0, cfg.skew[1:0]} + `LPC_SKEW_BASE;

    always_ff @(posedge core_clk) begin
        if (sysRst) begin
            ph_q     <= '0;
            colClk_q <= 1'b0;
        end else begin
            ph_q <= phNext;
            if (phNext == riseAt) begin
                colClk_q <= 1'b1;
            end else if (phNext == riseAt + `LPC_CLK_HIGH) begin
                colClk_q <= 1'b0;
            end
        end
    end

    assign columnOutputClock = colClk_q;

    // ****************************************
    // APB slave
    // ****************************************
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic [31:0] status;
    logic        setup;

    assign setup  = psel & ~penable;
    assign status = {4'h0, hCnt_q, 12'h000, frameOdd_q, rowStart_q,
                     polarity_q, lineSt_q};

    always_ff @(posedge core_clk) begin
        if (sysRst) begin
            ctrl_q <= `LPC_CTRL_RST;
        end else if (psel && penable && pready_q && pwrite
                     && paddr == `LPC_CTRL_ADDR) begin
            ctrl_q <= pwdata[`LPC_CTRL_MSB:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (sysRst) begin
            prdata_q  <= '0;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= setup;
            if (setup) begin
                pslverr_q <= paddr != `LPC_CTRL_ADDR
                             && paddr != `LPC_STAT_ADDR;
                if (pwrite) begin
                    prdata_q <= '0;
                end else if (paddr == `LPC_CTRL_ADDR) begin
                    prdata_q <= 32'(ctrl_q);
                end else if (paddr == `LPC_STAT_ADDR) begin
                    prdata_q <= status;
                end else begin
                    prdata_q <= '0;
                end
            end
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sysRst);

    chk_start_width: assert property (horizStart_q && pixTick_q |=> !horizStart_q)
        else $error("start pulse longer than one pixel clock");
    chk_data_lead: assert property ($rose(valid_q[2]) && !cfg.failOn |-> hCnt_q == `LPC_HS_LEAD)
        else $error("first data not two pixels after start");
    chk_latch_rise: assert property ($rose(pulse_q[0]) |->
        hCnt_q == (cfg.wide ? `LPC_LL_AT_W : `LPC_LL_AT_N))
        else $error("line latch rose at wrong count");
    chk_latch_width: assert property ($fell(pulse_q[0]) && !llLong |->
        hiCnt_q[0] == (cfg.wide ? `LPC_LL_W_W : `LPC_LL_W_N))
        else $error("line latch width wrong");
    chk_gate_rise: assert property ($rose(pulse_q[1]) |->
        hCnt_q == (cfg.wide ? `LPC_GE_AT_W : `LPC_GE_AT_N))
        else $error("gate enable rose at wrong count");
    chk_gate_width: assert property ($fell(pulse_q[1]) && cfg.reversalOption < `LPC_RO_GE2
        |-> hiCnt_q[1] == (cfg.wide ? `LPC_GE_W_W : `LPC_GE_W_N))
        else $error("gate enable width wrong");
    chk_shift_rise: assert property ($rose(pulse_q[2]) |->
        hCnt_q == (cfg.wide ? `LPC_SC_AT_W : `LPC_SC_AT_N))
        else $error("row shift clock rose at wrong count");
    chk_shift_width: assert property ($fell(pulse_q[2]) |->
        hiCnt_q[2] == (cfg.wide ? `LPC_SC_W_W : `LPC_SC_W_N))
        else $error("row shift clock width wrong");
    chk_row_edges: assert property ($changed(rowStart_q) |-> hCnt_q == rowAt)
        else $error("row start edge at wrong count");
    chk_rev_point: assert property ($changed(polarity_q) |-> hCnt_q == revAt)
        else $error("polarity toggled at wrong count");
    chk_apb_ready: assert property (setup |=> pready_q ##1 !pready_q)
        else $error("APB ready not one cycle after setup");

    cov_row_start: cover property ($rose(rowStart_q));
    cov_polarity: cover property ($changed(polarity_q));
    cov_ctrl_write: cover property (psel && penable && pready_q && pwrite);
    cov_fail_drop: cover property (pixTick_q && deRise && failZone);
endmodule : lpc_timing

// >>> tb/lpc_driver_model.sv
// Column and row driver model that times the control pulses in pixel ticks
`timescale 1ns/10ps
module lpc_driver_model (
    input  wire logic                   core_clk,   // Core clock
    input  wire logic                   rst,        // Sync reset
    input  wire logic                   pixelClock, // Link pixel clock
    input  wire lpc_pkg::lpc_ctrl_out_t ctrlOut,    // Driver pulses
    output logic [5:0][11:0]            riseAt,     // Tick of each rise
    output logic [5:0][11:0]            width,      // Ticks high, at fall
    output logic [11:0]                 polAt,      // Tick of polarity change
    output logic [11:0]                 lineLen,    // Ticks start to start
    output logic [3:0]                  polCnt,     // Polarity changes
    output logic [3:0]                  rowRises    // Row start rises
);
    // ************************************
    // Pulse timing
    // ************************************
    logic [2:0]       syncQ;
    logic [5:0]       prevQ;
    logic [11:0]      hPosQ;
    logic [5:0][11:0] runQ;
    logic             tick;

    // Own tick detector: a fixed lag against the design cancels out in differences
    assign tick = syncQ[1] & ~syncQ[2];

    always_ff @(posedge core_clk) begin
        if (rst) begin
            {syncQ, prevQ, hPosQ, runQ, riseAt, width} <= '0;
            {polAt, lineLen, polCnt, rowRises} <= '0;
        end else begin
            syncQ <= {syncQ[1:0], pixelClock};
            prevQ <= ctrlOut;
            if (tick) begin
                hPosQ <= hPosQ + 12'h001;
                for (int i = 0; i < 6; i++) begin
                    runQ[i] <= runQ[i] + 12'h001;
                end
            end
            for (int i = 0; i < 6; i++) begin
                if (ctrlOut[i] && !prevQ[i]) begin
                    riseAt[i] <= hPosQ;
                    runQ[i] <= 12'h000;
                end
                if (!ctrlOut[i] && prevQ[i]) begin
                    width[i] <= runQ[i];
                end
            end
            if (ctrlOut.horizStartPulse && !prevQ[5]) begin
                hPosQ <= 12'h000;
                lineLen <= hPosQ;
            end
            if (ctrlOut.polarityReversal != prevQ[0]) begin
                polAt <= hPosQ;
                polCnt <= polCnt + 4'h1;
            end
            if (ctrlOut.rowStartPulse && !prevQ[1]) begin
                rowRises <= rowRises + 4'h1;
            end
        end
    end
endmodule : lpc_driver_model

// >>> tb/testbench.sv
// Self-checking bench for the panel control timing block
`timescale 1ns/10ps
module testbench;
    // ************************************
    // Signals, clocks and instances
    // ************************************
    logic                   core_clk = 1'b0;
    logic                   pixelClock = 1'b0;
    logic                   rst = 1'b1;
    logic                   systemResetN = 1'b0;
    logic                   dataEnable = 1'b0;
    logic [23:0]            rgbIn = 24'hfc8040;
    logic                   psel = 1'b0;
    logic                   penable = 1'b0;
    logic                   pwrite = 1'b0;
    logic [11:0]            paddr = 12'h000;
    logic [31:0]            pwdata = 32'h00000000;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
    lpc_pkg::lpc_ctrl_out_t ctrlOut;
    logic [17:0]            colourOut;
    logic [5:0][11:0]       riseAt;
    logic [5:0][11:0]       width;
    logic [11:0]            polAt;
    logic [11:0]            lineLen;
    logic [3:0]             polCnt;
    logic [3:0]             rowRises;
    logic                   colClk;
    logic [31:0]            rd;
    logic                   err;
    int                     n_errors = 0;
    int                     n_compared = 0;
    int                     cycles = 0;

    always #4 core_clk = ~core_clk;
    // Link clock is free running and out of phase with the core clock
    initial #3 forever #32 pixelClock = ~pixelClock;

    lpc_timing u_lpc_timing (.core_clk(core_clk), .rst(rst), .systemResetN(systemResetN),
        .pixelClock(pixelClock), .dataEnable(dataEnable), .rgbIn(rgbIn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ctrlOut(ctrlOut),
        .colourOut(colourOut), .columnOutputClock(colClk));
    lpc_driver_model u_lpc_driver_model (.core_clk(core_clk), .rst(rst),
        .pixelClock(pixelClock), .ctrlOut(ctrlOut), .riseAt(riseAt), .width(width),
        .polAt(polAt), .lineLen(lineLen), .polCnt(polCnt), .rowRises(rowRises));

    // ************************************
    // Shared tasks
    // ************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        // Only the bench timeout ends a wait for the slave
        while (pready !== 1'b1) begin
            @(posedge core_clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic ticks(input int n);
        repeat (n) @(negedge pixelClock);
        @(posedge core_clk);
    endtask : ticks

    // One line; a stray enable drop at tick stray, when nonzero
    task automatic line(input int act, input int total, input int stray, input logic [17:0] c);
        dataEnable <= 1'b1;
        if (stray > 0) begin
            ticks(stray);
            dataEnable <= 1'b0;
            ticks(2);
            dataEnable <= 1'b1;
            ticks(act - stray - 2);
        end else begin
            ticks(act);
        end
        check(colourOut, c);
        dataEnable <= 1'b0;
        ticks(total - act);
    endtask : line

    // ************************************
    // Scenarios
    // ************************************
    task automatic narrow_single();
        int hiN;
        apb(1'b1, 12'h000, 32'h00000000);
        ticks(40);
        line(1024, 1750, 0, 18'h3f810);
        check(width[5], 12'd1);
        check(riseAt[4], 12'd1031);
        check(width[4], 12'd8);
        check(riseAt[3], 12'd904);
        check(width[3], 12'd159);
        check(riseAt[2], 12'd1031);
        check(width[2], 12'd684);
        check(riseAt[1], 12'd368);
        check(polAt, 12'd390);
        // Eight core cycles span one pixel: clock high for three of them
        hiN = 0;
        repeat (8) begin
            @(posedge core_clk);
            hiN += int'(colClk);
        end
        check(hiN, 32'd3);
        $display("test narrow_single done");
    endtask : narrow_single

    task automatic option_long();
        apb(1'b1, 12'h000, 32'h0000000c);
        apb(1'b0, 12'h000, 32'h00000000);
        check(rd, 32'h0000000c);
        line(1024, 1750, 0, 18'h3f810);
        check(width[4], 12'd17);
        check(width[3], 12'd226);
        check(width[1], lineLen);
        check(polAt, 12'd390);
        check(polCnt, 4'd2);
        $display("test option_long done");
    endtask : option_long

    task automatic wide_fail();
        apb(1'b1, 12'h000, 32'h00000113);
        rgbIn <= 24'h13579b;
        line(1280, 2010, 500, 18'h04566);
        check(riseAt[4], 12'd1285);
        check(width[4], 12'd10);
        check(riseAt[3], 12'd1147);
        check(width[3], 12'd180);
        check(riseAt[2], 12'd1283);
        line(1280, 2010, 0, 18'h04566);
        check(width[2], 12'd724);
        check(polAt, 12'd567);
        check(polCnt, 4'd3);
        check(rowRises, 4'd1);
        $display("test wide_fail done");
    endtask : wide_fail

    task automatic pin_reset();
        apb(1'b1, 12'h004, 32'hffffffff);
        check(err, 1'b0);
        apb(1'b0, 12'h008, 32'h00000000);
        check(rd, 32'h00000000);
        check({31'h0, err}, 32'h00000001);
        systemResetN <= 1'b0;
        repeat (4) @(posedge core_clk);
        check({26'h0, ctrlOut}, 32'h00000000);
        systemResetN <= 1'b1;
        repeat (3) @(posedge core_clk);
        apb(1'b0, 12'h000, 32'h00000000);
        check(rd, 32'h00000000);
        $display("test pin_reset done");
    endtask : pin_reset

    // ************************************
    // Run control
    // ************************************
    task automatic results();
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 80000) begin
            n_errors++;
            results();
        end
    end

    initial begin
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        systemResetN <= 1'b1;
        repeat (3) @(posedge core_clk);
        narrow_single();
        option_long();
        wide_fail();
        pin_reset();
        results();
    end
endmodule : testbench
